// *** src/led_color_group_select_pkg.sv ***
// Shared constants and carriers for LED selection decode and brightness monitor
package led_color_group_select_pkg;

  // ----------------------------------------
  // Selection code layout
  // ----------------------------------------
  localparam int SEL_W      = 4;
  localparam int COLOR_LSB  = 0;
  localparam int GROUP_LSB  = 2;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [1:0] FIELD_BLANK = 2'h0;
  localparam logic [1:0] FIELD_RED   = 2'h1;
  localparam logic [1:0] FIELD_GREEN = 2'h2;
  localparam logic [1:0] FIELD_BLUE  = 2'h3;

  // ----------------------------------------
  // Widths and register map
  // ----------------------------------------
  localparam int NUM_GROUPS = 4;
  localparam int NUM_COLORS = 3;
  localparam int THR_W      = 12;
  localparam int CNT_W      = 16;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // Photo thresholds: index = group*4 + colour(1..3)
  localparam logic [7:0] REG_PHOTO_THR_BASE = 8'h00;
  localparam logic [7:0] REG_PULSE_LIM_BASE = 8'h40;
  localparam logic [7:0] REG_CTRL           = 8'h50;
  localparam logic [7:0] REG_OVB_THR        = 8'h54;
  localparam logic [7:0] REG_HOLDOFF        = 8'h58;
  localparam logic [7:0] REG_STATUS         = 8'h5c;

  localparam int CTRL_DISC_BIT  = 0;
  localparam int CTRL_OVB_EN    = 1;
  localparam int CTRL_OVB_LOWBW = 2;

  localparam logic [THR_W-1:0] THR_RST     = 12'hfff;
  localparam logic [CNT_W-1:0] LIMIT_RST   = 16'hffff;
  localparam logic [CNT_W-1:0] HOLDOFF_RST = 16'h0064;

  // Drive enable off time for the on/off/on toggle
  localparam int DRV_OFF_NS  = 20;
  localparam int CLK_NS      = 10;
  localparam logic [3:0] DRV_OFF_CYC = 4'((DRV_OFF_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    COLOR_NONE,
    COLOR_RED,
    COLOR_GREEN,
    COLOR_BLUE
  } color_e;

  typedef struct packed {
    logic       drv_on;
    logic       blanking;
    logic       force_shunt;
    color_e     color;
    logic [1:0] group;
  } decode_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

endpackage

// *** src/led_color_group_select_decode.sv ***
// Registered decode of the LED selection code
`timescale 1ns/1ps
`default_nettype none
module led_color_group_select_decode
  import led_color_group_select_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Selection code in
  input  wire logic [SEL_W-1:0]        led_color_group_select,
  // Decoded out
  output led_color_group_select_pkg::decode_s         dec_q
);
  import led_color_group_select_pkg::*;

  decode_s dec_d;
  logic [1:0] lo;
  logic [1:0] hi;

  always_comb begin
    lo    = led_color_group_select[COLOR_LSB +: 2];
    hi    = led_color_group_select[GROUP_LSB +: 2];
    dec_d = '0;
    if (led_color_group_select == SEL_OFF) begin
      dec_d.force_shunt = 1'b1;
      dec_d.color       = COLOR_NONE;
    end else if (lo == FIELD_BLANK) begin
      dec_d.blanking = 1'b1;
      dec_d.color    = color_e'(hi);
    end else begin
      dec_d.drv_on = 1'b1;
      dec_d.color  = color_e'(lo);
      dec_d.group  = hi;
    end
  end

  // One edge for all decoded fields avoids mixed-code glitches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dec_q <= '{drv_on: 1'b0, blanking: 1'b0, force_shunt: 1'b1, color: COLOR_NONE, group: 2'h0};
    end else begin
      dec_q <= dec_d;
    end
  end
endmodule
`default_nettype wire

// *** src/led_pulse_ctrl.sv ***
// Discontinuous pulse control: drive enable toggle, holdoff filter, width limit
`timescale 1ns/1ps
`default_nettype none
module led_pulse_ctrl
  import led_color_group_select_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Mode and settings
  input  wire logic                    disc_mode,
  input  wire logic                    drv_on,
  input  wire logic [CNT_W-1:0]        holdoff_cyc,
  input  wire logic [CNT_W-1:0]        pulse_limit,
  // Controller and comparator
  input  wire logic                    shunt_request,
  input  wire logic                    photo_cmp_raw,
  // Results
  output logic                         drive_pulse_q,
  output logic                         pulse_end_q,
  output logic                         photo_compare_out,
  output logic                         limit_hit_q,
  output logic                         pulse_active_q
);
  import led_color_group_select_pkg::*;

  typedef enum logic [1:0] {
    P_IDLE,
    P_DRV_OFF,
    P_RUN,
    P_HOLD
  } pstate_e;

  pstate_e          st_q;
  logic             req_q;
  logic             cmp_q;
  logic [3:0]       off_q;
  logic [CNT_W-1:0] cnt_q;
  logic             req_fall;
  logic             cmp_fall;

  assign req_fall = req_q & ~shunt_request;
  assign cmp_fall = cmp_q & ~photo_cmp_raw;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_q <= 1'b1;
      cmp_q <= 1'b1;
    end else begin
      req_q <= shunt_request;
      cmp_q <= photo_cmp_raw;
    end
  end

  // ----------------------------------------
  // Pulse sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q        <= P_IDLE;
      off_q       <= 4'h0;
      cnt_q       <= '0;
      pulse_end_q <= 1'b0;
      limit_hit_q <= 1'b0;
    end else begin
      pulse_end_q <= 1'b0;
      limit_hit_q <= 1'b0;
      if (!disc_mode || !drv_on) begin
        st_q <= P_IDLE;
      end else begin
        unique case (st_q)
          P_IDLE: begin
            if (req_fall) begin
              st_q  <= P_DRV_OFF;
              off_q <= DRV_OFF_CYC;
            end
          end
          P_DRV_OFF: begin
            off_q <= off_q - 4'h1;
            if (off_q == 4'h1) begin
              st_q  <= P_RUN;
              cnt_q <= '0;
            end
          end
          P_RUN: begin
            cnt_q <= cnt_q + 1'b1;
            if (cmp_fall) begin
              st_q        <= P_HOLD;
              pulse_end_q <= 1'b1;
              cnt_q       <= '0;
            end else if (cnt_q >= pulse_limit) begin
              // No comparator edge to filter: next request taken at once
              st_q        <= P_IDLE;
              pulse_end_q <= 1'b1;
              limit_hit_q <= 1'b1;
              cnt_q       <= '0;
            end
          end
          P_HOLD: begin
            // Comparator edges ignored here
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q >= holdoff_cyc) begin
              st_q <= P_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign drive_pulse_q  = (st_q != P_DRV_OFF);
  assign pulse_active_q = (st_q == P_RUN);

  // Comparator output: low from accepted edge through holdoff
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      photo_compare_out <= 1'b1;
    end else begin
      photo_compare_out <= !(disc_mode && drv_on &&
                             ((st_q == P_RUN && cmp_fall) || (st_q == P_HOLD && cnt_q < holdoff_cyc)));
    end
  end
endmodule
`default_nettype wire

// *** src/led_select_monitor.sv ***
// LED selection decode and brightness monitor top
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// How it works
// - Code 0000 disables driver, forces shunt high, all colour selects low.
// - Low bits zero selects blanking; upper bits pick red, green, blue.
// - Nonzero low bits enable driver; low bits colour, upper bits group.
// - Four threshold sets, group picks set for the current colour.
// - Large capacitor select only during discontinuous operation.
// - Falling comparator output marks each pulse reaching threshold.
// - Secondary amplifier above programmable threshold flags over-brightness.
// - Over-brightness uses high or low bandwidth amplifier output.
// - Shunt request falling edge toggles drive enable off then on.
// - First comparator fall acts; later edges ignored during holdoff.
// - Per-colour time limit expiry ends pulse by enabling shunt.
// ----------------------------------------
module led_select_monitor
  import led_color_group_select_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Register port
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [DATA_W-1:0]            reg_rdata,
  // Controller pins
  input  wire logic [SEL_W-1:0]        led_color_group_select,
  input  wire logic                    shunt_request,
  // Analog front end, digitised
  input  wire logic                    photo_cmp_raw,
  input  wire logic [THR_W-1:0]        secondary_photo_amp_hbw,
  input  wire logic [THR_W-1:0]        secondary_photo_amp_lbw,
  // Outputs to power stage and controller
  output logic                         inductor_drive_enable,
  output logic                         low_ohm_shunt_enable,
  output logic                         large_cap_select,
  output logic                         photo_compare_out,
  output logic                         sel_red,
  output logic                         sel_green,
  output logic                         sel_blue,
  output logic                         blanking_current,
  output logic [THR_W-1:0]             photo_threshold,
  output logic                         over_bright
);
  import led_color_group_select_pkg::*;

  decode_s          dec;
  logic [THR_W-1:0] thr_q [NUM_GROUPS*4];
  logic [CNT_W-1:0] lim_q [4];
  logic [2:0]       ctrl_q;
  logic [THR_W-1:0] ovb_thr_q;
  logic [CNT_W-1:0] holdoff_q;
  logic             ovb_sticky_q;
  logic             lim_sticky_q;
  logic             drv_pulse;
  logic             pulse_end;
  logic             limit_hit;
  logic             pulse_act;
  logic             shunt_q;
  logic [3:0]       thr_idx;
  logic [THR_W-1:0] amp_sel;
  logic             ovb_now;
  logic             disc;

  assign disc = ctrl_q[CTRL_DISC_BIT];

  // ----------------------------------------
  // Decode and pulse control
  // ----------------------------------------
  led_color_group_select_decode u_dec (
    .clk_sys                (clk_sys),
    .rst                    (rst),
    .led_color_group_select (led_color_group_select),
    .dec_q                  (dec)
  );

  led_pulse_ctrl u_pulse (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .disc_mode         (disc),
    .drv_on            (dec.drv_on),
    .holdoff_cyc       (holdoff_q),
    .pulse_limit       (lim_q[dec.color]),
    .shunt_request     (shunt_request),
    .photo_cmp_raw     (photo_cmp_raw),
    .drive_pulse_q     (drv_pulse),
    .pulse_end_q       (pulse_end),
    .photo_compare_out (photo_compare_out),
    .limit_hit_q       (limit_hit),
    .pulse_active_q    (pulse_act)
  );

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GROUPS*4; gi++) begin : g_thr
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          thr_q[gi] <= THR_RST;
        end else if (reg_wr && reg_addr == REG_PHOTO_THR_BASE + 8'(gi*4)) begin
          thr_q[gi] <= reg_wdata[THR_W-1:0];
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_lim
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          lim_q[gi] <= LIMIT_RST;
        end else if (reg_wr && reg_addr == REG_PULSE_LIM_BASE + 8'(gi*4)) begin
          lim_q[gi] <= reg_wdata[CNT_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q    <= 3'h0;
      ovb_thr_q <= THR_RST;
      holdoff_q <= HOLDOFF_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_q <= reg_wdata[2:0];
      end
      if (reg_addr == REG_OVB_THR) begin
        ovb_thr_q <= reg_wdata[THR_W-1:0];
      end
      if (reg_addr == REG_HOLDOFF) begin
        holdoff_q <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Over-brightness compare
  // ----------------------------------------
  assign amp_sel = ctrl_q[CTRL_OVB_LOWBW] ? secondary_photo_amp_lbw : secondary_photo_amp_hbw;
  assign ovb_now = ctrl_q[CTRL_OVB_EN] && (amp_sel > ovb_thr_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      over_bright <= 1'b0;
    end else begin
      over_bright <= ovb_now;
    end
  end

  // Sticky status: a new event beats a same-cycle clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovb_sticky_q <= 1'b0;
      lim_sticky_q <= 1'b0;
    end else begin
      if (ovb_now) begin
        ovb_sticky_q <= 1'b1;
      end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[0]) begin
        ovb_sticky_q <= 1'b0;
      end
      if (limit_hit) begin
        lim_sticky_q <= 1'b1;
      end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[1]) begin
        lim_sticky_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Shunt and drive outputs
  // ----------------------------------------
  // Shunt drops on request fall, comes back when pulse ends
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shunt_q <= 1'b1;
    end else if (!dec.drv_on) begin
      shunt_q <= 1'b1;
    end else if (!disc) begin
      shunt_q <= shunt_request;
    end else if (pulse_end || shunt_request) begin
      shunt_q <= 1'b1;
    end else if (pulse_act || !drv_pulse) begin
      // Held high after pulse end until the next accepted request
      shunt_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inductor_drive_enable <= 1'b0;
      low_ohm_shunt_enable  <= 1'b1;
      large_cap_select      <= 1'b0;
      sel_red               <= 1'b0;
      sel_green             <= 1'b0;
      sel_blue              <= 1'b0;
      blanking_current      <= 1'b0;
      photo_threshold       <= THR_RST;
    end else begin
      inductor_drive_enable <= (dec.drv_on || dec.blanking) && drv_pulse;
      low_ohm_shunt_enable  <= dec.force_shunt | shunt_q;
      large_cap_select      <= disc;
      sel_red               <= dec.color == COLOR_RED;
      sel_green             <= dec.color == COLOR_GREEN;
      sel_blue              <= dec.color == COLOR_BLUE;
      blanking_current      <= dec.blanking;
      photo_threshold       <= thr_q[thr_idx];
    end
  end

  assign thr_idx = {dec.group, dec.color};

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr < REG_PULSE_LIM_BASE && reg_addr[1:0] == 2'h0) begin
        reg_rdata <= DATA_W'(thr_q[reg_addr[5:2]]);
      end else if (reg_addr >= REG_PULSE_LIM_BASE && reg_addr < REG_CTRL && reg_addr[1:0] == 2'h0) begin
        reg_rdata <= DATA_W'(lim_q[reg_addr[3:2]]);
      end else if (reg_addr == REG_CTRL) begin
        reg_rdata <= DATA_W'(ctrl_q);
      end else if (reg_addr == REG_OVB_THR) begin
        reg_rdata <= DATA_W'(ovb_thr_q);
      end else if (reg_addr == REG_HOLDOFF) begin
        reg_rdata <= DATA_W'(holdoff_q);
      end else if (reg_addr == REG_STATUS) begin
        reg_rdata <= DATA_W'({pulse_act, over_bright, lim_sticky_q, ovb_sticky_q});
      end
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// *** dv/led_select_monitor_props.sv ***
// Port-level checks for the LED select monitor top
`timescale 1ns/1ps
`default_nettype none
module led_select_monitor_props
  import led_color_group_select_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Controller and front end
  input wire logic [SEL_W-1:0]  led_color_group_select,
  input wire logic              shunt_request,
  input wire logic              photo_cmp_raw,
  input wire logic [THR_W-1:0]  secondary_photo_amp_hbw,
  input wire logic [THR_W-1:0]  secondary_photo_amp_lbw,
  // Outputs
  input wire logic              inductor_drive_enable,
  input wire logic              low_ohm_shunt_enable,
  input wire logic              large_cap_select,
  input wire logic              photo_compare_out,
  input wire logic              sel_red,
  input wire logic              sel_green,
  input wire logic              sel_blue,
  input wire logic              blanking_current,
  input wire logic              over_bright
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Shadows
  // ----------------------------------------
  logic [SEL_W-1:0] sel1_q;
  logic [SEL_W-1:0] sel2_q;
  logic [2:0]       ctrl_q;
  logic [THR_W-1:0] ovt_q;
  logic [1:0]       col;
  logic             ovb_exp;
  // Two stages: input register plus output register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel1_q <= 4'h0;
      sel2_q <= 4'h0;
    end else begin
      sel1_q <= led_color_group_select;
      sel2_q <= sel1_q;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= 3'h0;
      ovt_q  <= THR_RST;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == REG_OVB_THR) begin
      ovt_q <= reg_wdata[THR_W-1:0];
    end
  end
  assign col = (sel2_q[1:0] != 2'h0) ? sel2_q[1:0] : sel2_q[3:2];
  assign ovb_exp = ctrl_q[1] && ((ctrl_q[2] ? secondary_photo_amp_lbw : secondary_photo_amp_hbw) > ovt_q);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence req_fall_s;
    $fell(shunt_request) && large_cap_select && photo_compare_out && (sel_red || sel_green || sel_blue)
      && !blanking_current;
  endsequence
  sequence toggle_s;
    ##[1:3] !inductor_drive_enable ##[1:3] inductor_drive_enable;
  endsequence
  sequence raw_fall_s;
    $fell(photo_cmp_raw) && large_cap_select && !low_ohm_shunt_enable && photo_compare_out;
  endsequence
  sequence shunt_drop_s;
    $fell(low_ohm_shunt_enable) && large_cap_select;
  endsequence
  off_code_a: assert property (sel2_q == SEL_OFF |-> !inductor_drive_enable && low_ohm_shunt_enable
    && !(sel_red || sel_green || sel_blue)) else $error("off code decode wrong");
  sel_decode_a: assert property ({sel_red, sel_green, sel_blue, blanking_current} ==
    {col == 2'h1, col == 2'h2, col == 2'h3, sel2_q[1:0] == 2'h0 && sel2_q != SEL_OFF})
    else $error("colour or blanking decode wrong");
  cap_sel_a: assert property (large_cap_select == $past(ctrl_q[0])) else $error("cap select wrong");
  cmp_fall_a: assert property (raw_fall_s |-> ##[1:4] !photo_compare_out) else $error("no compare fall");
  cmp_hold_a: assert property ($fell(photo_compare_out) |=> !photo_compare_out [*8])
    else $error("compare out left holdoff early");
  drv_toggle_a: assert property (req_fall_s |-> toggle_s) else $error("drive toggle missing");
  pulse_end_a: assert property (shunt_drop_s |-> ##[1:70] low_ohm_shunt_enable)
    else $error("pulse not ended by shunt");
  shunt_hold_a: assert property ($rose(low_ohm_shunt_enable) && large_cap_select && !shunt_request
    |=> low_ohm_shunt_enable) else $error("shunt dropped after pulse end");
  ovb_flag_a: assert property (over_bright == $past(ovb_exp)) else $error("over bright flag wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside slot");
endmodule
bind led_select_monitor led_select_monitor_props led_select_monitor_props_i (.clk_sys, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .led_color_group_select, .shunt_request, .photo_cmp_raw,
  .secondary_photo_amp_hbw, .secondary_photo_amp_lbw, .inductor_drive_enable, .low_ohm_shunt_enable,
  .large_cap_select, .photo_compare_out, .sel_red, .sel_green, .sel_blue, .blanking_current, .over_bright);
`default_nettype wire

// *** dv/led_ctrl_partner.sv ***
// Display controller model: shunt requests and pulse counting
`timescale 1ns/1ps
`default_nettype none
module led_ctrl_partner (
  // Clock
  input  wire logic       clk_sys,
  // Command from bench
  input  wire logic       start,
  input  wire logic [3:0] pulses,
  // Device side
  input  wire logic       photo_compare_out,
  output logic            shunt_request,
  // Result
  output logic            done,
  output logic [3:0]      falls,
  output logic            photodiode_lost
);
  int k;
  logic [3:0] nf;
  initial begin
    shunt_request = 1'b1;
    done = 1'b0;
    falls = 4'h0;
    photodiode_lost = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (start) begin
        nf = 4'h0;
        for (int p = 0; p < pulses; p++) begin
          shunt_request <= 1'b0;
          k = 0;
          do begin
            @(posedge clk_sys);
            k++;
          end while (photo_compare_out && k < 80);
          // Only a seen fall is counted; the wait for it ends after 80 cycles
          if (!photo_compare_out) nf = nf + 4'h1;
          shunt_request <= 1'b1;
          k = 0;
          while (!photo_compare_out && k < 200) begin
            @(posedge clk_sys);
            k++;
          end
          repeat (4) @(posedge clk_sys);
        end
        falls <= nf;
        photodiode_lost <= (nf == 4'h0);
        done <= 1'b1;
        @(posedge clk_sys);
        done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the LED select monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import led_color_group_select_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic [SEL_W-1:0]  code = 4'h0;
  logic [THR_W-1:0]  amp_h = 12'h0;
  logic [THR_W-1:0]  amp_l = 12'h0;
  logic              photo_cmp_raw = 1'b1;
  logic              start = 1'b0;
  logic              look = 1'b0;
  logic              rd_p = 1'b0;
  logic              light = 1'b0;
  logic [3:0]        np = 4'h0;
  logic [5:0]        cnt = 6'h0;
  logic              shunt_request, ide, shunt, cap, cmp_out, s_r, s_g, s_b, blank, ovb, done, lost;
  logic [THR_W-1:0]  thr_out, ovt;
  logic [THR_W-1:0]  thr_tab [16];
  logic [3:0]        falls;
  logic [31:0]       expq [$];
  logic [31:0]       obs, e;
  int                mismatches = 0;
  int                total_checks = 0;
  int                seed = 89;
  int                k;
  initial forever #5 clk_sys = ~clk_sys;
  led_select_monitor led_select_monitor_i (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .led_color_group_select(code), .shunt_request, .photo_cmp_raw, .secondary_photo_amp_hbw(amp_h),
    .secondary_photo_amp_lbw(amp_l), .inductor_drive_enable(ide), .low_ohm_shunt_enable(shunt),
    .large_cap_select(cap), .photo_compare_out(cmp_out), .sel_red(s_r), .sel_green(s_g), .sel_blue(s_b),
    .blanking_current(blank), .photo_threshold(thr_out), .over_bright(ovb));
  led_ctrl_partner led_ctrl_partner_i (.clk_sys, .start, .pulses(np), .photo_compare_out(cmp_out),
    .shunt_request, .done, .falls, .photodiode_lost(lost));
  // Threshold only meaningful for driver-enabled codes
  assign obs = {12'h0, (code[1:0] != 2'h0) ? thr_out : 12'h0, ovb, s_r, s_g, s_b, blank, ide, shunt, cap};
  // ----------------------------------------
  // Photodiode and result monitor
  // ----------------------------------------
  // Light crosses, then bounces inside holdoff
  always @(posedge clk_sys) begin
    cnt <= (cnt != 6'h0) ? ((cnt == 6'd40) ? 6'h0 : cnt + 6'h1) : ((light && !shunt) ? 6'h1 : 6'h0);
    photo_cmp_raw <= !(cnt inside {[6'd10:6'd13], [6'd16:6'd29]});
  end
  always @(posedge clk_sys) begin
    rd_p <= reg_rd;
    if (rd_p || look) begin
      e = expq.pop_front();
      check(rd_p ? reg_rdata : obs, e);
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic peek(input logic [31:0] x);
    expq.push_back(x);
    look <= 1'b1;
    @(posedge clk_sys);
    look <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] dexp(input logic [3:0] c, input logic ob);
    logic [1:0] col;
    col = (c[1:0] != 2'h0) ? c[1:0] : c[3:2];
    dexp = {12'h0, (c[1:0] != 2'h0) ? thr_tab[c] : 12'h0, ob, col == 2'h1, col == 2'h2, col == 2'h3,
      c[1:0] == 2'h0 && c != 4'h0, c != 4'h0, 1'b1, 1'b0};
  endfunction
  task automatic burst(input logic [3:0] n);
    np <= n;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    k = 0;
    while (!done && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    if (!done) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(REG_HOLDOFF, 32'(HOLDOFF_RST));
    rd(REG_PULSE_LIM_BASE + 8'h4, 32'(LIMIT_RST));
    rd(REG_PHOTO_THR_BASE + 8'h4, 32'(THR_RST));
    rd(REG_CTRL, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80, 32'h0);
    // Slot index equals the selection code
    for (int c = 0; c < 16; c++) begin
      thr_tab[c] = THR_W'($random(seed));
      wr(REG_PHOTO_THR_BASE + 8'(4 * c), 32'(thr_tab[c]));
    end
    rd(REG_PHOTO_THR_BASE + 8'h3c, 32'(thr_tab[15]));
    for (int c = 0; c < 16; c++) begin
      code <= 4'(c);
      repeat (3) @(posedge clk_sys);
      peek(dexp(4'(c), 1'b0));
    end
    for (int i = 0; i < 24; i++) begin
      ovt = THR_W'($random(seed));
      amp_h <= THR_W'($random(seed));
      amp_l <= THR_W'($random(seed));
      wr(REG_OVB_THR, 32'(ovt));
      wr(REG_CTRL, {29'h0, i[1:0], 1'b0});
      repeat (2) @(posedge clk_sys);
      peek(dexp(code, i[0] && ((i[1] ? amp_l : amp_h) > ovt)));
    end
    wr(REG_CTRL, 32'h1);
    wr(REG_STATUS, 32'h3);
    for (int c = 1; c < 4; c++) wr(REG_PULSE_LIM_BASE + 8'(4 * c), 32'd40);
    code <= 4'h5;
    light <= 1'b1;
    repeat (3) @(posedge clk_sys);
    burst(4'h3);
    check(32'(falls), 32'h3);
    check(32'(lost), 32'h0);
    light <= 1'b0;
    burst(4'h2);
    check(32'(lost), 32'h1);
    rd(REG_STATUS, 32'h2);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
